// *** src/crf_filter_ts.sv ***
// receive acceptance filter, timestamp counter and interval prescaler
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module crf_filter_ts
    import crf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // mode and channel status
    input wire logic global_reset_mode,
    input wire logic chan_halted,
    input wire logic classical_only,
    input wire logic nom_bit_tick,
    // protocol engine events
    input wire logic frm_sof,
    input wire logic frm_res_pt,
    input wire logic frm_valid,
    input wire crf_frame_t frm_info,
    input wire logic res_recessive,
    input wire logic tx_done,
    // results
    output crf_store_t store_info,
    output logic store_valid,
    output logic dlc_err,
    output logic discard,
    output logic hist_wr,
    output logic [15:0] hist_ts,
    output logic proto_exc,
    output logic form_err,
    output logic err_frame_req,
    output logic interval_tick,
    output logic [15:0] ts_count
);
    logic rst_s1_q;
    logic rst_sync_b;
    logic [31:0] global_cfg_low_q;
    logic [15:0] interval_prescale_q;
    logic [1:0] common_fifo_cfg_low_q;
    logic [4:0] rule_count_q;
    logic [31:0] rule_id_q [CRF_NRULES];
    logic [31:0] rule_mask_q [CRF_NRULES];
    logic [31:0] rule_p0_q [CRF_NRULES];
    logic [31:0] rule_p1_q [CRF_NRULES];
    logic [15:0] ts_q;
    logic [15:0] ts_cap_q;
    logic [15:0] ivl_cnt_q;
    logic [3:0] x10_cnt_q;
    logic presc_tick;
    crf_state_t state_q;
    crf_frame_t frm_q;
    logic [15:0] frm_ts_q;
    logic [3:0] idx_q;
    logic hit;
    logic lb_ok;
    logic [31:0] cmp_mask;
    logic [31:0] frm_word;
    logic rtr_eff;
    logic dlc_short;
    logic cap_now;
    logic accept;
    logic [1:0] cap_sel;
    logic [31:0] p0;
    logic [31:0] p1;
    logic [2:0] fifo_sel;
    logic [2:0] fifo_keep;
    logic tbl_hit;
    logic [3:0] tbl_idx;

    // two-stage reset release
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_sync_b <= rst_s1_q;
        end
    end

    assign tbl_hit = (reg_addr[9:8] == CRF_TBL_SEL);
    assign tbl_idx = reg_addr[7:4];
    assign cap_sel = global_cfg_low_q[CRF_B_CAPLO+1:CRF_B_CAPLO];

    // global configuration, writes only land in global reset mode
    // writes gated by reset
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            global_cfg_low_q <= CRF_CFG_RST;
            interval_prescale_q <= CRF_PRESC_RST;
            common_fifo_cfg_low_q <= 2'h0;
        end else if (reg_wr && global_reset_mode) begin
            if (reg_addr == CRF_GCFG_LOW_OFS) begin
                global_cfg_low_q <= reg_wdata;
            end
            if (reg_addr == CRF_GCFG_HIGH_OFS) begin
                interval_prescale_q <= reg_wdata[15:0];
            end
            if (reg_addr == CRF_CF_CFG_OFS) begin
                common_fifo_cfg_low_q <= reg_wdata[1:0];
            end
        end
    end

    // rule count, clamped so the scan never leaves the table
    // count capped
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rule_count_q <= 5'h00;
        end else if (reg_wr && global_reset_mode && reg_addr == CRF_RULE_CFG_OFS) begin
            rule_count_q <= (reg_wdata[4:0] > CRF_RULE_MAX) ? CRF_RULE_MAX : reg_wdata[4:0];
        end
    end

    // rule table entries, one writer per entry
    for (genvar g = 0; g < CRF_NRULES; g++) begin : g_rule
        always_ff @(posedge clk_sys or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
                rule_id_q[g] <= CRF_CFG_RST;
                rule_mask_q[g] <= CRF_CFG_RST;
                rule_p0_q[g] <= CRF_CFG_RST;
                rule_p1_q[g] <= CRF_CFG_RST;
            end else if (reg_wr && tbl_hit && tbl_idx == 4'(g)) begin
                unique case (reg_addr[3:2])
                    CRF_W_ID: rule_id_q[g] <= reg_wdata;
                    CRF_W_MASK: rule_mask_q[g] <= reg_wdata;
                    CRF_W_P0: rule_p0_q[g] <= reg_wdata;
                    CRF_W_P1: rule_p1_q[g] <= reg_wdata;
                endcase
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= CRF_UNMAPPED;
        end else if (!reg_rd) begin
            reg_rdata <= CRF_UNMAPPED;
        end else if (tbl_hit) begin
            unique case (reg_addr[3:2])
                CRF_W_ID: reg_rdata <= rule_id_q[tbl_idx];
                CRF_W_MASK: reg_rdata <= rule_mask_q[tbl_idx];
                CRF_W_P0: reg_rdata <= rule_p0_q[tbl_idx];
                CRF_W_P1: reg_rdata <= rule_p1_q[tbl_idx];
            endcase
        end else begin
            unique case (reg_addr)
                CRF_GCFG_LOW_OFS: reg_rdata <= global_cfg_low_q;
                CRF_GCFG_HIGH_OFS: reg_rdata <= {16'h0000, interval_prescale_q};
                CRF_CF_CFG_OFS: reg_rdata <= {30'h0, common_fifo_cfg_low_q};
                CRF_RULE_CFG_OFS: reg_rdata <= {27'h0, rule_count_q};
                CRF_TS_OFS: reg_rdata <= {16'h0000, ts_q};
                CRF_STAT_OFS: reg_rdata <= {27'h0, idx_q, state_q == CRF_SCAN};
                default: reg_rdata <= CRF_UNMAPPED;
            endcase
        end
    end

    // timestamp counter; bit-clock mode only counts while the channel runs
    // counter
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ts_q <= 16'h0000;
        end else if (!global_cfg_low_q[CRF_B_TSSEL]) begin
            ts_q <= ts_q + 16'h0001;
        end else if (nom_bit_tick && classical_only && !chan_halted) begin
            ts_q <= ts_q + 16'h0001;
        end
    end
    assign ts_count = ts_q;

    // capture point select; classical frames get RES pulse at SOF from engine
    // capture select
    always_comb begin
        unique case (cap_sel)
            CRF_CAP_SOF: cap_now = frm_sof;
            CRF_CAP_VALID: cap_now = frm_valid;
            CRF_CAP_RES: cap_now = frm_res_pt;
            default: cap_now = frm_sof;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ts_cap_q <= 16'h0000;
        end else if (cap_now) begin
            ts_cap_q <= ts_q;
        end
    end

    // history stamp for own transmitted frames
    // transmit stamp
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hist_wr <= 1'b0;
            hist_ts <= 16'h0000;
        end else begin
            hist_wr <= tx_done;
            if (tx_done) begin
                hist_ts <= ts_cap_q;
            end
        end
    end

    // RES bit handling for FD frames
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            proto_exc <= 1'b0;
            form_err <= 1'b0;
            err_frame_req <= 1'b0;
        end else begin
            proto_exc <= res_recessive && frm_info.fd && global_cfg_low_q[CRF_B_RESEXC];
            form_err <= res_recessive && frm_info.fd && !global_cfg_low_q[CRF_B_RESEXC];
            err_frame_req <= res_recessive && frm_info.fd && !global_cfg_low_q[CRF_B_RESEXC];
        end
    end

    // interval prescaler; a zero prescale simply stalls the tick
    // prescale divider
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ivl_cnt_q <= 16'h0000;
        end else if (common_fifo_cfg_low_q[CRF_B_ISS] || interval_prescale_q == 16'h0000) begin
            ivl_cnt_q <= 16'h0000;
        end else if (presc_tick) begin
            ivl_cnt_q <= 16'h0000;
        end else begin
            ivl_cnt_q <= ivl_cnt_q + 16'h0001;
        end
    end
    assign presc_tick = !common_fifo_cfg_low_q[CRF_B_ISS] && interval_prescale_q != 16'h0000
        && ivl_cnt_q == interval_prescale_q - 16'h0001;

    // optional extra divide by ten
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            x10_cnt_q <= 4'h0;
            interval_tick <= 1'b0;
        end else if (!common_fifo_cfg_low_q[CRF_B_X10]) begin
            x10_cnt_q <= 4'h0;
            interval_tick <= presc_tick;
        end else begin
            interval_tick <= presc_tick && x10_cnt_q == CRF_X10_LAST;
            if (presc_tick) begin
                x10_cnt_q <= (x10_cnt_q == CRF_X10_LAST) ? 4'h0 : x10_cnt_q + 4'h1;
            end
        end
    end

    // compare of the scanned rule against the latched frame
    // no format field
    always_comb begin
        rtr_eff = frm_q.fd ? frm_q.rrs : frm_q.rtr;
        frm_word = {frm_q.ide, rtr_eff, 1'b0, frm_q.id};
        cmp_mask = {rule_mask_q[idx_q][31:30], 1'b0, rule_mask_q[idx_q][28:0]};
        lb_ok = frm_q.self_tx ? (global_cfg_low_q[CRF_B_MME] && rule_id_q[idx_q][CRF_B_LB])
            : !rule_id_q[idx_q][CRF_B_LB];
        hit = lb_ok && (((frm_word ^ rule_id_q[idx_q]) & cmp_mask) == 32'h0000_0000);
    end

    assign p0 = rule_p0_q[idx_q];
    assign p1 = rule_p1_q[idx_q];
    assign dlc_short = global_cfg_low_q[CRF_B_DCE] && (frm_q.dlc < p0[CRF_B_DLC+3:CRF_B_DLC]);
    // own frames with mirror off are never presented to the rules
    assign accept = frm_valid && (!frm_info.self_tx || global_cfg_low_q[CRF_B_MME]);

    // rxbuf is one number, so two FIFOs only without it
    always_comb begin
        fifo_sel = {p1[2], p1[1], p1[0]};
        fifo_keep = 3'h0;
        if (p0[CRF_B_RXEN]) begin
            fifo_keep[0] = fifo_sel[0];
            fifo_keep[1] = fifo_sel[1] && !fifo_sel[0];
            fifo_keep[2] = fifo_sel[2] && fifo_sel[1:0] == 2'h0;
        end else begin
            fifo_keep[0] = fifo_sel[0];
            fifo_keep[1] = fifo_sel[1];
            fifo_keep[2] = fifo_sel[2] && !(fifo_sel[0] && fifo_sel[1]);
        end
    end

    // scan sequencer, one rule per cycle, frames arriving during a scan are dropped
    // ascending first hit
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_q <= CRF_IDLE;
            idx_q <= 4'h0;
            frm_q <= '0;
            frm_ts_q <= 16'h0000;
        end else begin
            unique case (state_q)
                CRF_IDLE: begin
                    if (accept && rule_count_q != 5'h00) begin
                        state_q <= CRF_SCAN;
                        idx_q <= 4'h0;
                        frm_q <= frm_info;
                        frm_ts_q <= (cap_sel == CRF_CAP_VALID) ? ts_q : ts_cap_q;
                    end
                end
                CRF_SCAN: begin
                    if (hit || {1'b0, idx_q} == rule_count_q - 5'h01) begin
                        state_q <= CRF_IDLE;
                    end else begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // outcome of a scan: store, dlc error or discard
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            store_valid <= 1'b0;
            dlc_err <= 1'b0;
            discard <= 1'b0;
            store_info <= '0;
        end else begin
            store_valid <= 1'b0;
            dlc_err <= 1'b0;
            discard <= (accept && rule_count_q == 5'h00 && state_q == CRF_IDLE)
                || (state_q == CRF_SCAN && !hit && {1'b0, idx_q} == rule_count_q - 5'h01);
            if (state_q == CRF_SCAN && hit) begin
                store_valid <= !dlc_short;
                dlc_err <= dlc_short;
                store_info.rxbuf_en <= p0[CRF_B_RXEN];
                store_info.rxbuf_num <= p0[CRF_B_RXNUM+3:CRF_B_RXNUM];
                store_info.rfifo0 <= fifo_keep[0];
                store_info.rfifo1 <= fifo_keep[1];
                store_info.cfifo <= fifo_keep[2];
                store_info.ts <= frm_ts_q;
                store_info.label16 <= p0[15:0];
                store_info.label2 <= p0[CRF_B_LBL2+1:CRF_B_LBL2];
                store_info.dlc <= (global_cfg_low_q[CRF_B_DCE] && global_cfg_low_q[CRF_B_DRE])
                    ? p0[CRF_B_DLC+3:CRF_B_DLC] : frm_q.dlc;
                store_info.zero_fill <= global_cfg_low_q[CRF_B_DCE] && global_cfg_low_q[CRF_B_DRE];
            end
        end
    end

    // checks on the block's own behaviour
    AST_TS_INC: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        !global_cfg_low_q[CRF_B_TSSEL] && !$past(global_cfg_low_q[CRF_B_TSSEL]) && $past(rst_sync_b)
        |-> ts_q == $past(ts_q) + 16'h0001)
        else $error("timestamp did not advance");
    AST_TS_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        ts_q == 16'hFFFF && !global_cfg_low_q[CRF_B_TSSEL] && !reg_wr |=> ts_q == 16'h0000)
        else $error("timestamp did not wrap");
    AST_TS_HALT: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        global_cfg_low_q[CRF_B_TSSEL] && chan_halted && !reg_wr |=> $stable(ts_q))
        else $error("timestamp ran while halted");
    AST_RES_EXC: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        res_recessive && frm_info.fd && global_cfg_low_q[CRF_B_RESEXC] |=> proto_exc && !form_err)
        else $error("RES exception missed");
    AST_RES_FORM: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        res_recessive && frm_info.fd && !global_cfg_low_q[CRF_B_RESEXC] |=> form_err && err_frame_req)
        else $error("RES form error missed");
    AST_SCAN_END: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        state_q == CRF_IDLE && accept |-> ##[1:17] (store_valid || dlc_err || discard))
        else $error("scan did not finish");
    AST_DEST_TWO: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        store_valid |-> $countones({store_info.rxbuf_en, store_info.rfifo0, store_info.rfifo1,
        store_info.cfifo}) <= 2)
        else $error("more than two destinations");
    AST_DLC_ERR: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        dlc_err |-> !store_valid && !discard)
        else $error("short frame stored");
    AST_COUNT_MAX: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        rule_count_q <= CRF_RULE_MAX)
        else $error("rule count above table size");
    AST_HIST_TS: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        tx_done |=> hist_wr && hist_ts == $past(ts_cap_q))
        else $error("history stamp wrong");
endmodule

// *** src/crf_pkg.sv ***
// package for the receive filter and timestamp block
package crf_pkg;
    // register byte offsets (10-bit address space)
    localparam logic [9:0] CRF_GCFG_LOW_OFS = 10'h000;
    localparam logic [9:0] CRF_GCFG_HIGH_OFS = 10'h004;
    localparam logic [9:0] CRF_CF_CFG_OFS = 10'h008;
    localparam logic [9:0] CRF_RULE_CFG_OFS = 10'h00C;
    localparam logic [9:0] CRF_TS_OFS = 10'h010;
    localparam logic [9:0] CRF_STAT_OFS = 10'h014;
    // rule table: 0x100 + rule*16 + word*4
    localparam logic [1:0] CRF_TBL_SEL = 2'h1;
    localparam logic [1:0] CRF_W_ID = 2'h0;
    localparam logic [1:0] CRF_W_MASK = 2'h1;
    localparam logic [1:0] CRF_W_P0 = 2'h2;
    localparam logic [1:0] CRF_W_P1 = 2'h3;
    // global_cfg_low fields
    localparam int CRF_B_DCE = 0;
    localparam int CRF_B_DRE = 1;
    localparam int CRF_B_MME = 2;
    localparam int CRF_B_TSSEL = 3;
    localparam int CRF_B_RESEXC = 4;
    localparam int CRF_B_CAPLO = 5;
    // common_fifo_cfg_low fields
    localparam int CRF_B_ISS = 0;
    localparam int CRF_B_X10 = 1;
    // rule word fields
    localparam int CRF_B_LB = 29;
    localparam int CRF_B_RTR = 30;
    localparam int CRF_B_IDE = 31;
    localparam int CRF_B_LBL2 = 16;
    localparam int CRF_B_DLC = 20;
    localparam int CRF_B_RXEN = 24;
    localparam int CRF_B_RXNUM = 25;
    // sizes and reset values
    localparam int CRF_NRULES = 16;
    localparam logic [4:0] CRF_RULE_MAX = 5'h10;
    localparam logic [31:0] CRF_CFG_RST = 32'h0000_0000;
    localparam logic [15:0] CRF_PRESC_RST = 16'h0001;
    localparam logic [3:0] CRF_X10_LAST = 4'h9;
    localparam logic [31:0] CRF_UNMAPPED = 32'h0000_0000;
    // capture point choices
    localparam logic [1:0] CRF_CAP_SOF = 2'h0;
    localparam logic [1:0] CRF_CAP_VALID = 2'h1;
    localparam logic [1:0] CRF_CAP_RES = 2'h2;

    // frame presented by the protocol engine at frame valid
    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic rrs;
        logic fd;
        logic [3:0] dlc;
        logic self_tx;
    } crf_frame_t;

    // store request towards buffers and FIFOs
    typedef struct packed {
        logic rxbuf_en;
        logic [3:0] rxbuf_num;
        logic rfifo0;
        logic rfifo1;
        logic cfifo;
        logic [15:0] ts;
        logic [15:0] label16;
        logic [1:0] label2;
        logic [3:0] dlc;
        logic zero_fill;
    } crf_store_t;

    typedef enum logic {CRF_IDLE, CRF_SCAN} crf_state_t;
endpackage

// *** testbench/crf_node_model.sv ***
// far-side node model: event pulses of one frame per request
`timescale 1ns/1ps
module crf_node_model
    import crf_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // request from the bench
    input wire logic send,
    input wire crf_frame_t info,
    input wire logic res_rec,
    // frame events
    output logic frm_sof,
    output logic frm_res_pt,
    output logic frm_valid,
    output logic res_recessive,
    output crf_frame_t frm_info
);
    // sof, res point three cycles on, valid two after that
    initial begin
        {frm_sof, frm_res_pt, frm_valid, res_recessive} = 4'h0;
        frm_info = '1;
        forever begin
            @(posedge clk_sys);
            if (send) begin
                frm_sof <= 1'b1;
                // classical frames have no res bit: point falls on sof
                frm_res_pt <= !info.fd;
                @(posedge clk_sys);
                {frm_sof, frm_res_pt} <= 2'h0;
                repeat (2) @(posedge clk_sys);
                frm_res_pt <= info.fd;
                res_recessive <= res_rec & info.fd;
                frm_info <= info;
                @(posedge clk_sys);
                {frm_res_pt, res_recessive} <= 2'h0;
                frm_info <= ~info;
                @(posedge clk_sys);
                frm_valid <= 1'b1;
                frm_info <= info;
                @(posedge clk_sys);
                frm_valid <= 1'b0;
                // scrambled so a stale sample never looks right
                frm_info <= ~info;
            end
        end
    end
endmodule

// *** testbench/crf_filter_ts_tb.sv ***
// self-checking bench for the receive filter and timestamp block
`timescale 1ns/1ps
module crf_filter_ts_tb;
    import crf_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic gmode = 1'b1;
    logic halted = 1'b0;
    logic classic = 1'b0;
    logic tick = 1'b0;
    logic send = 1'b0;
    logic res_rec = 1'b0;
    logic tx_done = 1'b0;
    crf_frame_t info = '0;
    crf_frame_t frm_info;
    crf_store_t st;
    logic [31:0] reg_rdata;
    logic [15:0] tsc, hts;
    logic sof, resp, fvalid, resrec, stv, dle, dis, hwr, pexc, ferr, efr, itick;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_res = 0;
    int code = 0;
    int n_hist = 0;
    int n_exc = 0;
    int n_form = 0;
    int last_tk = 0;
    int gap = 0;

    crf_filter_ts u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_reset_mode(gmode),
        .chan_halted(halted), .classical_only(classic), .nom_bit_tick(tick), .frm_sof(sof),
        .frm_res_pt(resp), .frm_valid(fvalid), .frm_info(frm_info), .res_recessive(resrec),
        .tx_done(tx_done), .store_info(st), .store_valid(stv), .dlc_err(dle), .discard(dis),
        .hist_wr(hwr), .hist_ts(hts), .proto_exc(pexc), .form_err(ferr), .err_frame_req(efr),
        .interval_tick(itick), .ts_count(tsc));
    crf_node_model u_node (.clk_sys(clk_sys), .send(send), .info(info), .res_rec(res_rec),
        .frm_sof(sof), .frm_res_pt(resp), .frm_valid(fvalid), .res_recessive(resrec), .frm_info(frm_info));

    always #4 clk_sys = ~clk_sys;

    // pulse tallies, tick spacing and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        n_res <= n_res + stv + dle + dis;
        code <= stv ? 1 : dle ? 2 : dis ? 3 : code;
        n_hist <= n_hist + hwr;
        n_exc <= n_exc + pexc;
        n_form <= n_form + ferr + efr;
        if (itick) begin
            gap <= cyc - last_tk;
            last_tk <= cyc;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(string w, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", w, exp, got);
        end
    endtask

    task automatic wr(logic [9:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [9:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // read data stands through the next edge, taken there before it clears
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic rdc(string w, logic [9:0] a, logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(w, exp, v);
    endtask

    task automatic rule(logic [3:0] i, logic [31:0] id, logic [31:0] mk, logic [31:0] p0, logic [31:0] p1);
        wr(10'h100 + {i, 4'h0}, id);
        wr(10'h104 + {i, 4'h0}, mk);
        wr(10'h108 + {i, 4'h0}, p0);
        wr(10'h10C + {i, 4'h0}, p1);
    endtask

    // one frame; r: 1 stored, 2 dlc error, 3 discarded, 0 none
    task automatic frame(crf_frame_t f, logic rr, output int r, output int s);
        int t0;
        t0 = n_res;
        @(posedge clk_sys);
        send <= 1'b1;
        info <= f;
        res_rec <= rr;
        @(posedge clk_sys);
        send <= 1'b0;
        s = cyc;
        for (int i = 0; i < 40 && n_res == t0; i++) @(posedge clk_sys);
        #1 r = (n_res == t0) ? 0 : code;
        // frames must stand far enough apart
        repeat (17) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        rdc("rule count", CRF_RULE_CFG_OFS, CRF_CFG_RST);
        rdc("prescale", CRF_GCFG_HIGH_OFS, {16'h0, CRF_PRESC_RST});
        rdc("unmapped", 10'h018, CRF_UNMAPPED);
        gmode <= 1'b0;
        wr(CRF_GCFG_HIGH_OFS, 32'h0000_0009);
        gmode <= 1'b1;
        rdc("gated", CRF_GCFG_HIGH_OFS, {16'h0, CRF_PRESC_RST});
        wr(CRF_RULE_CFG_OFS, 32'h0000_001F);
        rdc("count clamp", CRF_RULE_CFG_OFS, {27'h0, CRF_RULE_MAX});
        $display("TB: registers done");
    endtask

    task automatic t_ts();
        logic [31:0] a, b;
        rd(CRF_TS_OFS, a);
        rd(CRF_TS_OFS, b);
        check("ts step", 32'h3, {16'h0, b[15:0] - a[15:0]});
        wr(CRF_GCFG_LOW_OFS, 32'h0000_0008);
        classic <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            halted <= h[0];
            rd(CRF_TS_OFS, a);
            repeat (5) begin
                @(posedge clk_sys);
                tick <= 1'b1;
                @(posedge clk_sys);
                tick <= 1'b0;
            end
            rd(CRF_TS_OFS, b);
            check("bit ts", h ? 32'h0 : 32'h5, {16'h0, b[15:0] - a[15:0]});
        end
        check("ts port", {16'h0, b[15:0]}, {16'h0, tsc});
        halted <= 1'b0;
        classic <= 1'b0;
        tx_done <= 1'b1;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("history", 32'h1, n_hist);
        wr(CRF_GCFG_HIGH_OFS, 32'h0000_0004);
        repeat (20) @(posedge clk_sys);
        check("tick gap", 32'h4, gap);
        wr(CRF_CF_CFG_OFS, 32'h0000_0002);
        repeat (100) @(posedge clk_sys);
        check("tick gap x10", 32'h28, gap);
        $display("TB: timers done");
    endtask

    task automatic t_capture();
        int r, s, s0;
        logic [15:0] t0;
        crf_frame_t f;
        f = '0;
        f.id = 29'h130;
        f.fd = 1'b1;
        f.rrs = 1'b1;
        for (int m = 0; m < 3; m++) begin
            wr(CRF_GCFG_LOW_OFS, {25'h0, m[1:0], 5'h0});
            frame(f, 1'b0, r, s);
            check("fd remote", 32'h1, r);
            if (m == 0) begin
                s0 = s;
                t0 = st.ts;
            end
            check("stamp", {16'h0, 16'(t0 + s - s0 + (m == 1 ? 5 : m == 2 ? 3 : 0))}, {16'h0, st.ts});
        end
        check("labels", 32'h0002_0130, {14'h0, st.label2, st.label16});
        frame(f, 1'b1, r, s);
        check("form error", 32'h2, n_form);
        wr(CRF_GCFG_LOW_OFS, 32'h0000_0010);
        frame(f, 1'b1, r, s);
        check("exception", 32'h1, n_exc);
        check("no error", 32'h2, n_form);
        tx_done <= 1'b1;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        @(posedge clk_sys);
        check("hist stamp", {16'h0, 16'(t0 + s - s0)}, {16'h0, hts});
        $display("TB: capture done");
    endtask

    task automatic t_filter();
        int r, s;
        crf_frame_t f;
        f = '0;
        f.id = 29'h121;
        f.dlc = 4'h8;
        frame(f, 1'b0, r, s);
        check("no match", 32'h3, r);
        f.id = 29'h120;
        frame(f, 1'b0, r, s);
        check("rule0 hit", 32'h1, r);
        check("dest", 32'h9A, {24'h0, st.rxbuf_en, st.rxbuf_num, st.rfifo0, st.rfifo1, st.cfifo});
        check("dlc kept", 32'h08, {27'h0, st.zero_fill, st.dlc});
        wr(CRF_GCFG_LOW_OFS, 32'h0000_0005);
        f.self_tx = 1'b1;
        frame(f, 1'b0, r, s);
        check("own frame", 32'h3, r);
        f.self_tx = 1'b0;
        f.dlc = 4'h4;
        frame(f, 1'b0, r, s);
        check("short dlc", 32'h2, r);
        wr(CRF_GCFG_LOW_OFS, 32'h0000_0007);
        f.dlc = 4'h8;
        frame(f, 1'b0, r, s);
        check("dlc replaced", 32'h16, {27'h0, st.zero_fill, st.dlc});
        // rule DLC cleared before the check is switched off
        wr(10'h108, 32'h0701_0010);
        wr(CRF_GCFG_LOW_OFS, 32'h0000_0000);
        f.dlc = 4'h4;
        frame(f, 1'b0, r, s);
        check("dlc unchecked", 32'h04, {27'h0, st.zero_fill, st.dlc});
        $display("TB: filter done");
    endtask

    task automatic finish_test();
        $display("TB: %0d checks, %0d mismatches", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        // rule 0: data 0x120; rule 1: remote or rrs 0x130
        rule(4'h0, 32'h0000_0120, 32'hDFFF_FFFF, 32'h0761_0010, 32'h0000_0002);
        rule(4'h1, 32'h4000_0130, 32'hDFFF_FFFF, 32'h0002_0130, 32'h0000_0005);
        wr(CRF_RULE_CFG_OFS, 32'h0000_0002);
        t_ts();
        t_capture();
        t_filter();
        finish_test();
    end
endmodule
